/* suart_defines.svh */
// Register indices, field positions, reset values and timing figures of the serial port
`ifndef SUART_DEFINES_SVH
`define SUART_DEFINES_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SU_IDX_LSC 3'h0
`define SU_IDX_RXD 3'h1
`define SU_IDX_TXD 3'h2
`define SU_IDX_ISTAT 3'h3
`define SU_IDX_ICLR 3'h4
`define SU_IDX_IEN 3'h5
// ----------------------------------------------------------------
// Field positions of line_status_control
// ----------------------------------------------------------------
`define SU_B_RATE 5
`define SU_B_RTS 4
`define SU_B_CTS 3
`define SU_B_OVF 2
`define SU_B_DR 1
`define SU_B_TBE 0
// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define SU_I_TBE 0
`define SU_I_RX 1
`define SU_I_OVF 2
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SU_RST_RATE 3'h0
`define SU_RST_RTS 1'b0
`define SU_RST_IEN 3'h7
`define SU_RATE_OFF 3'h7
// ----------------------------------------------------------------
// Timing: clock rate in Hz and baud rates in bit/s
// ----------------------------------------------------------------
`define SU_CLK_HZ 25000000
`define SU_BAUD_0 115200
`define SU_BAUD_1 57600
`define SU_BAUD_2 38400
`define SU_BAUD_3 19200
`define SU_BAUD_4 9600
`define SU_BAUD_5 4800
`define SU_BAUD_6 2400
`endif

/* suart_pkg.sv */
// Types and the baud divisor function of the serial port
`include "suart_defines.svh"
package su_pkg;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} su_apb_req_t;
	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} su_apb_rsp_t;
	typedef enum logic [1:0] {SU_TX_IDLE, SU_TX_START, SU_TX_DATA, SU_TX_STOP} su_tx_st_t;
	typedef enum logic [1:0] {SU_RX_IDLE, SU_RX_START, SU_RX_DATA, SU_RX_STOP} su_rx_st_t;
	// Clock cycles per bit for a rate code; the off code reuses the slowest rate
	function automatic logic [15:0] su_baud_div(input logic [2:0] rate, input int unsigned clk_hz);
		int unsigned b;
		case (rate)
			3'h0: b = `SU_BAUD_0;
			3'h1: b = `SU_BAUD_1;
			3'h2: b = `SU_BAUD_2;
			3'h3: b = `SU_BAUD_3;
			3'h4: b = `SU_BAUD_4;
			3'h5: b = `SU_BAUD_5;
			default: b = `SU_BAUD_6;
		endcase
		return 16'(clk_hz / b);
	endfunction : su_baud_div
endpackage : su_pkg

/* suart_top.sv */
// Serial port with receive queue, one-byte transmit holding buffer and APB registers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "suart_defines.svh"
module su_uart_top #(
	parameter int unsigned CLK_HZ = `SU_CLK_HZ,
	parameter int unsigned RXQ_DEPTH = 5
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire su_pkg::su_apb_req_t apb_req,
	output su_pkg::su_apb_rsp_t apb_rsp,
	// Serial pins
	input wire logic rxd,
	input wire logic cts,
	output logic txd,
	output logic rts,
	// Interrupt
	output logic irq
);
	localparam int unsigned PW = (RXQ_DEPTH > 1) ? $clog2(RXQ_DEPTH) : 1;
	localparam int unsigned CW = $clog2(RXQ_DEPTH + 1);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (RXQ_DEPTH < 1 || RXQ_DEPTH > 15) begin : g_bad_depth
		$error("RXQ_DEPTH must lie between 1 and 15");
	end
	// Counters are 16 bits; the fastest rate needs a few cycles per bit
	if (CLK_HZ / 2400 > 65535 || CLK_HZ / 115200 < 4) begin : g_bad_clk
		$error("CLK_HZ does not suit the bit counters");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] rate;
		logic rts;
		logic ovf;
		logic [2:0] ist;
		logic [2:0] ien;
		logic [2:0] cts_s;
		logic cts_f;
		logic [2:0] rxd_s;
		logic rxd_f;
		logic hold_full;
		logic [7:0] hold;
		su_pkg::su_tx_st_t tx_st;
		logic [15:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic txd;
		su_pkg::su_rx_st_t rx_st;
		logic [15:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [RXQ_DEPTH-1:0][7:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic pop;
		logic [2:0] clr;
		logic covf;
		logic irq;
	} su_state_t;

	su_state_t s_q;
	su_state_t s_d;
	logic setup;
	logic acc;
	logic mapped;
	logic [2:0] idx;
	logic push;
	logic push_ok;
	logic pop_now;
	logic tbe_ev;

	// Word-aligned indices 0 to 5 within the block; anything else errors
	function automatic logic su_mapped(input logic [31:0] a);
		return (a[31:5] == 27'h0) && (a[1:0] == 2'h0) && (a[4:2] <= `SU_IDX_IEN);
	endfunction : su_mapped

	// Bus phases and address decode
	assign setup = apb_req.psel & ~apb_req.penable;
	assign acc = apb_req.psel & apb_req.penable & s_q.rdy;
	assign idx = apb_req.paddr[4:2];
	assign mapped = su_mapped(apb_req.paddr);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0] div;
		logic off;
		div = su_pkg::su_baud_div(s_q.rate, CLK_HZ);
		off = (s_q.rate == `SU_RATE_OFF);
		s_d = s_q;
		push = 1'b0;
		push_ok = 1'b0;
		pop_now = 1'b0;
		// Pin synchronisers; a level counts once the last two stages agree
		s_d.rxd_s = {s_q.rxd_s[1:0], rxd};
		s_d.cts_s = {s_q.cts_s[1:0], cts};
		if (s_q.rxd_s[1] == s_q.rxd_s[2]) begin
			s_d.rxd_f = s_q.rxd_s[2];
		end
		if (s_q.cts_s[1] == s_q.cts_s[2]) begin
			s_d.cts_f = s_q.cts_s[2];
		end
		// Setup phase: capture read data so pready and prdata come from flops
		if (setup) begin
			s_d.rdy = 1'b1;
			s_d.err = ~mapped;
			s_d.rdata = 32'h00000000;
			s_d.pop = 1'b0;
			s_d.clr = 3'h0;
			s_d.covf = 1'b0;
			if (!apb_req.pwrite && mapped) begin
				case (idx)
					`SU_IDX_LSC: begin
						s_d.rdata[7:0] = {s_q.rate, s_q.rts, s_q.cts_f, s_q.ovf,
							s_q.cnt != '0, ~s_q.hold_full};
						// Only what was reported gets acknowledged
						s_d.clr = s_q.ist;
						s_d.covf = s_q.ovf;
					end
					`SU_IDX_RXD: begin
						s_d.rdata[7:0] = s_q.mem[s_q.rp];
						s_d.pop = (s_q.cnt != '0);
					end
					`SU_IDX_ISTAT: s_d.rdata[2:0] = s_q.ist;
					`SU_IDX_IEN: s_d.rdata[2:0] = s_q.ien;
					default: s_d.rdata = 32'h00000000;
				endcase
			end
		end
		// Access phase end: writes land and read side effects happen here
		if (acc) begin
			s_d.rdy = 1'b0;
			if (apb_req.pwrite && mapped) begin
				case (idx)
					`SU_IDX_LSC: begin
						s_d.rate = apb_req.pwdata[`SU_B_RATE +: 3];
						s_d.rts = apb_req.pwdata[`SU_B_RTS];
					end
					`SU_IDX_TXD: begin
						// A write into a full buffer is dropped
						if (!s_q.hold_full) begin
							s_d.hold = apb_req.pwdata[7:0];
							s_d.hold_full = 1'b1;
						end
					end
					`SU_IDX_ICLR: s_d.ist = s_q.ist & ~apb_req.pwdata[2:0];
					`SU_IDX_IEN: s_d.ien = apb_req.pwdata[2:0];
					default: s_d.rdy = 1'b0;
				endcase
			end else if (!apb_req.pwrite && mapped) begin
				if (idx == `SU_IDX_LSC) begin
					s_d.ist = s_q.ist & ~s_q.clr;
					s_d.ovf = s_q.ovf & ~s_q.covf;
				end
				pop_now = (idx == `SU_IDX_RXD) && s_q.pop;
			end
		end
		// Transmitter
		case (s_q.tx_st)
			su_pkg::SU_TX_IDLE: begin
				if (s_q.hold_full && !off) begin
					s_d.tx_sh = s_q.hold;
					s_d.hold_full = 1'b0;
					s_d.tx_st = su_pkg::SU_TX_START;
					s_d.tx_cnt = div - 16'h0001;
					s_d.txd = 1'b0;
				end
			end
			su_pkg::SU_TX_START: begin
				s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
				if (s_q.tx_cnt == 16'h0000) begin
					s_d.tx_st = su_pkg::SU_TX_DATA;
					s_d.tx_cnt = div - 16'h0001;
					s_d.tx_bit = 3'h0;
					s_d.txd = s_q.tx_sh[0];
				end
			end
			su_pkg::SU_TX_DATA: begin
				s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
				if (s_q.tx_cnt == 16'h0000) begin
					s_d.tx_cnt = div - 16'h0001;
					s_d.tx_bit = s_q.tx_bit + 3'h1;
					s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
					s_d.txd = s_q.tx_sh[1];
					if (s_q.tx_bit == 3'h7) begin
						s_d.tx_st = su_pkg::SU_TX_STOP;
						s_d.txd = 1'b1;
					end
				end
			end
			su_pkg::SU_TX_STOP: begin
				s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
				if (s_q.tx_cnt == 16'h0000) begin
					s_d.tx_st = su_pkg::SU_TX_IDLE;
				end
			end
			default: s_d.tx_st = su_pkg::SU_TX_IDLE;
		endcase
		// Receiver; start bit is rechecked mid-bit to reject glitches
		case (s_q.rx_st)
			su_pkg::SU_RX_IDLE: begin
				if (!s_q.rxd_f) begin
					s_d.rx_st = su_pkg::SU_RX_START;
					s_d.rx_cnt = {1'b0, div[15:1]};
				end
			end
			su_pkg::SU_RX_START: begin
				s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
				if (s_q.rx_cnt == 16'h0000) begin
					s_d.rx_st = s_q.rxd_f ? su_pkg::SU_RX_IDLE : su_pkg::SU_RX_DATA;
					s_d.rx_cnt = div - 16'h0001;
					s_d.rx_bit = 3'h0;
				end
			end
			su_pkg::SU_RX_DATA: begin
				s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
				if (s_q.rx_cnt == 16'h0000) begin
					s_d.rx_sh = {s_q.rxd_f, s_q.rx_sh[7:1]};
					s_d.rx_bit = s_q.rx_bit + 3'h1;
					s_d.rx_cnt = div - 16'h0001;
					if (s_q.rx_bit == 3'h7) begin
						s_d.rx_st = su_pkg::SU_RX_STOP;
					end
				end
			end
			su_pkg::SU_RX_STOP: begin
				s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
				if (s_q.rx_cnt == 16'h0000) begin
					s_d.rx_st = su_pkg::SU_RX_IDLE;
					// A low stop bit is a framing error; that byte is dropped
					push = s_q.rxd_f;
				end
			end
			default: s_d.rx_st = su_pkg::SU_RX_IDLE;
		endcase
		// The off code parks both engines with the line idle
		if (off) begin
			s_d.tx_st = su_pkg::SU_TX_IDLE;
			s_d.rx_st = su_pkg::SU_RX_IDLE;
			s_d.txd = 1'b1;
			push = 1'b0;
		end
		// Receive queue; a pop in the same cycle frees room for the push
		push_ok = push && ((s_q.cnt != CW'(RXQ_DEPTH)) || pop_now);
		if (push_ok) begin
			s_d.mem[s_q.wp] = s_q.rx_sh;
			s_d.wp = (s_q.wp == PW'(RXQ_DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
		end
		if (pop_now) begin
			s_d.rp = (s_q.rp == PW'(RXQ_DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
		end
		s_d.cnt = CW'(s_q.cnt + CW'(push_ok) - CW'(pop_now));
		// Events set after the clears so a simultaneous event is kept
		tbe_ev = s_q.hold_full && !s_d.hold_full;
		if (push && !push_ok) begin
			s_d.ovf = 1'b1;
			s_d.ist[`SU_I_OVF] = 1'b1;
		end
		if (tbe_ev) begin
			s_d.ist[`SU_I_TBE] = 1'b1;
		end
		if (s_d.cnt != '0) begin
			s_d.ist[`SU_I_RX] = 1'b1;
		end
		s_d.irq = (|(s_d.ist & s_d.ien)) && (s_d.rate != `SU_RATE_OFF);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.rate <= `SU_RST_RATE;
			s_q.rts <= `SU_RST_RTS;
			s_q.ien <= `SU_RST_IEN;
			s_q.rxd_s <= 3'h7;
			s_q.rxd_f <= 1'b1;
			s_q.txd <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign apb_rsp = '{prdata: s_q.rdata, pready: s_q.rdy, pslverr: s_q.err};
	assign txd = s_q.txd;
	assign rts = s_q.rts;
	assign irq = s_q.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_lsc_write;
		acc && apb_req.pwrite && mapped && idx == `SU_IDX_LSC;
	endsequence
	sequence s_rxd_setup;
		setup && !apb_req.pwrite && mapped && idx == `SU_IDX_RXD && s_q.cnt != '0;
	endsequence

	property p_rate_wr;
		s_lsc_write |=> s_q.rate == $past(apb_req.pwdata[7:5]);
	endproperty
	a_rate_wr: assert property (p_rate_wr) else $error("rate field not written");

	property p_rts_pin;
		s_lsc_write |=> rts == $past(apb_req.pwdata[4]);
	endproperty
	a_rts_pin: assert property (p_rts_pin) else $error("rts pin does not follow bit 4");

	property p_off_quiet;
		s_q.rate == `SU_RATE_OFF |-> !irq && txd && s_q.tx_st == su_pkg::SU_TX_IDLE;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("port active while off");

	property p_qbound;
		s_q.cnt <= CW'(RXQ_DEPTH);
	endproperty
	a_qbound: assert property (p_qbound) else $error("receive queue over depth");

	property p_ovf;
		push && s_q.cnt == CW'(RXQ_DEPTH) && !pop_now |=> s_q.ovf && s_q.cnt == CW'(RXQ_DEPTH);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_rx_irq;
		s_q.cnt != '0 && s_q.ien[`SU_I_RX] && s_q.rate != `SU_RATE_OFF
			&& !(acc && apb_req.pwrite && idx inside {`SU_IDX_LSC, `SU_IDX_IEN}) |=> irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("irq low with queued data");

	property p_tbe_irq;
		$fell(s_q.hold_full) |-> s_q.ist[`SU_I_TBE];
	endproperty
	a_tbe_irq: assert property (p_tbe_irq) else $error("empty edge not latched");

	property p_txd_load;
		acc && apb_req.pwrite && mapped && idx == `SU_IDX_TXD && !s_q.hold_full
			|=> s_q.hold_full && s_q.hold == $past(apb_req.pwdata[7:0]);
	endproperty
	a_txd_load: assert property (p_txd_load) else $error("holding buffer not loaded");

	property p_rx_read;
		s_rxd_setup ##1 acc |-> apb_rsp.prdata[7:0] == $past(s_q.mem[s_q.rp])
			##1 s_q.cnt == $past(s_q.cnt) - CW'(1) + CW'($past(push_ok));
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("receive read wrong");

	property p_start_bit;
		s_q.tx_st == su_pkg::SU_TX_START |-> !txd;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit not low");

endmodule : su_uart_top

/* su_serial_peer.sv */
// Behavioural model of the far serial device: sends frames on rxd, decodes frames from txd
`timescale 1ns/10ps
module su_serial_peer (
	// Clock and bit time in clock cycles
	input wire logic pclk,
	input wire logic [15:0] div,
	// Serial pins
	input wire logic txd,
	output logic rxd,
	// Last character decoded from the block
	output logic [7:0] got_byte,
	output logic got_stop,
	output logic got_stb
);
	// --------------------
	// Sender
	// --------------------
	initial rxd = 1'b1;
	// One frame, then the line stays high for gap cycles (gap 0 gives back-to-back frames)
	task automatic send(input logic [7:0] b, input logic [15:0] gap);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			rxd <= f[i];
			repeat (div - 16'd1) @(posedge pclk);
		end
		repeat (gap) @(posedge pclk);
	endtask : send
	// --------------------
	// Receiver
	// --------------------
	// Samples mid-bit; a start bit that is gone by mid-bit is taken as a glitch
	initial begin
		got_stb = 1'b0;
		got_byte = 8'h00;
		got_stop = 1'b0;
		forever begin
			@(negedge txd);
			repeat (div / 16'd2) @(posedge pclk);
			if (txd === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (div) @(posedge pclk);
					got_byte[i] = txd;
				end
				repeat (div) @(posedge pclk);
				got_stop = txd;
				got_stb = 1'b1;
				@(posedge pclk);
				got_stb = 1'b0;
			end
		end
	end
endmodule : su_serial_peer

/* su_uart_top_tb.sv */
// Self-checking bench of the serial port with its far-side device model
`timescale 1ns/10ps
`include "suart_defines.svh"
module su_uart_top_tb;
	// Slow clock figure keeps bit times short: 8 cycles per bit at the fastest rate
	localparam int unsigned CLK_HZ = 921600;
	localparam int unsigned BAUD [7] = '{`SU_BAUD_0, `SU_BAUD_1, `SU_BAUD_2, `SU_BAUD_3,
		`SU_BAUD_4, `SU_BAUD_5, `SU_BAUD_6};
	logic pclk;
	logic presetn;
	su_pkg::su_apb_req_t apb_req;
	su_pkg::su_apb_rsp_t apb_rsp;
	logic rxd, cts, txd, rts, irq, got_stop, got_stb;
	logic [15:0] div;
	logic [7:0] got_byte;
	logic [7:0] b [6];
	logic [32:0] rd_q [$];
	logic [7:0] tx_q [$];
	logic [2:0] rate_v;
	logic rts_v;
	int bad_count, num_checks, seed;
	// --------------------
	// Clock, block and far device
	// --------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	su_uart_top #(.CLK_HZ(CLK_HZ), .RXQ_DEPTH(5)) dut_u (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .rxd(rxd), .cts(cts), .txd(txd), .rts(rts), .irq(irq));
	su_serial_peer peer_u (.pclk(pclk), .div(div), .txd(txd), .rxd(rxd), .got_byte(got_byte),
		.got_stop(got_stop), .got_stb(got_stb));
	// --------------------
	// Checking and closing
	// --------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// Expected status word: error bit, zeros, then the register fields
	function automatic logic [32:0] st(input logic ovf, input logic dr, input logic tbe);
		return {25'h0, rate_v, rts_v, cts, ovf, dr, tbe};
	endfunction : st
	// Read data is matched to the oldest note at the completing edge
	always @(posedge pclk) begin
		if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
			check({apb_rsp.pslverr, apb_rsp.prdata}, rd_q.pop_front());
		end
	end
	// A decoded character with no note pending pops an unknown and fails
	always @(posedge got_stb) begin
		check({24'h0, got_stop, got_byte}, {24'h0, 1'b1, tx_q.pop_front()});
	end
	// --------------------
	// Drivers
	// --------------------
	// One APB transfer; the request stands until pready is sampled high
	task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
		input logic [32:0] exp);
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= {27'h0, idx, 2'h0};
		apb_req.pwdata <= {24'($random(seed)), wd};
		if (!wr) rd_q.push_back(exp);
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// No fixed wait count is assumed; only the watchdog ends a missing answer
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb
	// Waits until every noted character came out, then lets the stop bit end
	task automatic wait_tx();
		// A character that never comes out is left to the watchdog
		while (tx_q.size() != 0) begin
			@(posedge pclk);
		end
		repeat (div) @(posedge pclk);
	endtask : wait_tx
	task automatic irq_is(input logic exp);
		@(negedge pclk);
		check({32'h0, irq}, {32'h0, exp});
	endtask : irq_is
	task automatic send_tx(input logic [7:0] v);
		tx_q.push_back(v);
		apb(1'b1, `SU_IDX_TXD, v, 33'h0);
	endtask : send_tx
	// --------------------
	// Tests
	// --------------------
	initial begin
		seed = 32'hfbf94ff1;
		apb_req = '0;
		presetn = 1'b0;
		cts = 1'b0;
		div = 16'd8;
		bad_count = 0;
		num_checks = 0;
		rate_v = 3'h0;
		rts_v = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		cts <= 1'($random(seed));
		repeat (4) @(posedge pclk);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
		apb(1'b0, `SU_IDX_IEN, 8'h00, 33'h7);
		apb(1'b0, `SU_IDX_ISTAT, 8'h00, 33'h0);
		apb(1'b0, 3'h6, 8'h00, 33'h100000000);
		$display("reset values done");
		// Every rate code; writes to read-only bits must not stick
		for (int c = 7; c >= 0; c--) begin
			rate_v = 3'(c);
			rts_v = 1'($random(seed));
			cts <= 1'($random(seed));
			apb(1'b1, `SU_IDX_LSC, {rate_v, rts_v, 4'hf}, 33'h0);
			apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
			check({32'h0, rts}, {32'h0, rts_v});
		end
		$display("status fields done");
		// One character at each rate, bit time from the rate table
		for (int c = 0; c < 7; c++) begin
			rate_v = 3'(c);
			div = 16'(CLK_HZ / BAUD[c]);
			apb(1'b1, `SU_IDX_LSC, {rate_v, rts_v, 4'h0}, 33'h0);
			send_tx(8'($random(seed)));
			wait_tx();
		end
		rate_v = 3'h0;
		div = 16'd8;
		apb(1'b1, `SU_IDX_LSC, {rate_v, rts_v, 4'h0}, 33'h0);
		irq_is(1'b1);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
		irq_is(1'b0);
		$display("rates done");
		// Three quick writes: one shifts, one waits, the third meets a full buffer
		for (int i = 0; i < 3; i++) begin
			b[i] = 8'($random(seed));
			apb(1'b1, `SU_IDX_TXD, b[i], 33'h0);
		end
		tx_q.push_back(b[0]);
		tx_q.push_back(b[1]);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b0));
		wait_tx();
		irq_is(1'b1);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
		irq_is(1'b0);
		$display("holding buffer done");
		// Masked event stays pending until cleared
		apb(1'b1, `SU_IDX_IEN, 8'h00, 33'h0);
		send_tx(8'($random(seed)));
		wait_tx();
		irq_is(1'b0);
		apb(1'b0, `SU_IDX_ISTAT, 8'h00, 33'h1);
		apb(1'b1, `SU_IDX_ICLR, 8'h01, 33'h0);
		apb(1'b0, `SU_IDX_ISTAT, 8'h00, 33'h0);
		apb(1'b1, `SU_IDX_IEN, 8'h07, 33'h0);
		apb(1'b0, `SU_IDX_IEN, 8'h00, 33'h7);
		$display("interrupt mask done");
		// Six characters into a five-byte queue, mixed spacing
		for (int i = 0; i < 6; i++) begin
			b[i] = 8'($random(seed));
			peer_u.send(b[i], 16'(i % 3));
		end
		repeat (16) @(posedge pclk);
		irq_is(1'b1);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b1, 1'b1, 1'b1));
		irq_is(1'b1);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, `SU_IDX_RXD, 8'h00, {25'h0, b[i]});
		end
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
		irq_is(1'b0);
		$display("receive queue done");
		// Port off silences a pending interrupt and receives nothing
		send_tx(8'($random(seed)));
		wait_tx();
		irq_is(1'b1);
		rate_v = 3'h7;
		apb(1'b1, `SU_IDX_LSC, {rate_v, rts_v, 4'h0}, 33'h0);
		irq_is(1'b0);
		peer_u.send(8'($random(seed)), 16'd0);
		repeat (16) @(posedge pclk);
		apb(1'b0, `SU_IDX_LSC, 8'h00, st(1'b0, 1'b0, 1'b1));
		irq_is(1'b0);
		$display("port off done");
		test_done();
	end
	// Cuts a hang short well after the tests should have ended
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		$display("watchdog expired");
		test_done();
	end
endmodule : su_uart_top_tb
